// ==== logic/qsif_status.sv ====
module qsif_status (
  input  wire logic                  i_clock,
  input  wire logic                  i_nrst,
  // classic wishbone slave
  input  wire logic                  i_wb_cyc,
  input  wire logic                  i_wb_stb,
  input  wire logic                  i_wb_we,
  input  wire logic [7:0]            i_wb_adr,
  input  wire logic [3:0]            i_wb_sel,
  input  wire logic [31:0]           i_wb_dat,
  output logic      [31:0]           o_wb_dat,
  output logic                       o_wb_ack,
  output logic                       o_wb_err,
  // hardware condition inputs
  input  wire qsif_pkg::qsif_dma_type i_dma,
  input  wire qsif_pkg::qsif_buf_type i_con_buf,
  input  wire qsif_pkg::qsif_buf_type i_rx_buf,
  input  wire qsif_pkg::qsif_buf_type i_tx_buf,
  input  wire logic                  i_sys_read_req,
  // interrupt request
  output logic                       o_irq
);
  import qsif_pkg::*;

  // ==========================================================
  // state
  logic [11:0] flags_q;     // sticky status flags
  logic [11:0] enable_q;    // interrupt enable mask
  logic [7:0]  con_lvl_q;   // control threshold
  logic [7:0]  rx_lvl_q;    // receive threshold
  logic [7:0]  tx_lvl_q;    // transmit threshold
  logic        boot_q;      // boot/xip mode
  logic        boot_hold_q; // rx threshold forced until first read
  logic [11:0] set_d;       // hardware set terms
  logic [11:0] clr_d;       // software clear terms
  logic        acc;         // new bus access this cycle
  logic        wr;          // write access
  logic        hit;         // mapped address
  logic        rd_status_q; // answer in flight is a status read

  // byte-lane mask over the flag bits: lane 0 holds bits 7:0, lane 1
  // bits 11:8; the upper lanes carry no flag, so their strobes are moot
  function automatic logic [11:0] lane_mask(input logic [3:0] sel);
    return {{4{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ==========================================================
  // bus decode; ack for one cycle, dropped before a new one
  assign acc = i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
  assign wr  = acc && i_wb_we;
  always_comb begin
    case (i_wb_adr)
      QSIF_STATUS_OFS, QSIF_CLEAR_OFS, QSIF_ENABLE_OFS,
      QSIF_LEVEL_OFS, QSIF_CONTROL_OFS: hit = 1'b1;
      default:                          hit = 1'b0;
    endcase
  end

  // ==========================================================
  // hardware set conditions
  always_comb begin
    set_d = '0;
    set_d[QSIF_DMA_ERR_BIT] = i_dma.bus_error;                // see RULE1
    set_d[QSIF_PKT_BIT]     = i_dma.pkt_done;                 // see RULE2
    set_d[QSIF_BD_BIT]      = i_dma.bd_done;                  // see RULE3
    set_d[QSIF_CON_THR_BIT] = i_con_buf.free_words > con_lvl_q; // see RULE4
    set_d[QSIF_CON_EMP_BIT] = i_con_buf.empty;                // see RULE5
    set_d[QSIF_CON_FUL_BIT] = i_con_buf.full;                 // see RULE6
    // boot mode: flag forced whatever the threshold, held until first read
    set_d[QSIF_RX_THR_BIT]  = (i_rx_buf.free_words > rx_lvl_q) ||
                              (boot_hold_q && boot_q);         // see RULE7 RULE10
    set_d[QSIF_RX_FUL_BIT]  = i_rx_buf.full;                  // see RULE8
    set_d[QSIF_RX_EMP_BIT]  = i_rx_buf.empty;                 // see RULE9
    set_d[QSIF_TX_THR_BIT]  = i_tx_buf.free_words > tx_lvl_q; // see RULE14
    set_d[QSIF_TX_FUL_BIT]  = i_tx_buf.full;                  // see RULE14
    set_d[QSIF_TX_EMP_BIT]  = i_tx_buf.empty;                 // see RULE14
  end

  // software clear: write one to status or clear register; the status
  // offset also clears so software can write back what it just read
  always_comb begin
    clr_d = '0;
    if (wr && (i_wb_adr == QSIF_STATUS_OFS || i_wb_adr == QSIF_CLEAR_OFS)) begin
      clr_d = i_wb_dat[11:0] & lane_mask(i_wb_sel);          // see RULE11
    end
  end

  // ==========================================================
  // sticky flags; set wins over clear
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_q <= QSIF_FLAG_RST;                               // see RULE12
    end else begin
      flags_q <= (flags_q & ~clr_d) | set_d;                  // see RULE15
    end
  end

  // boot hold: armed by reset, dropped only by the first system read;
  // it forces the flag only while boot mode is on, so a plain start is
  // unaffected; limitation: boot mode must be set before that first read
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      boot_hold_q <= 1'b1;
    end else if (i_sys_read_req) begin
      boot_hold_q <= 1'b0;                                    // see RULE10
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      enable_q  <= QSIF_EN_RST;
      con_lvl_q <= QSIF_LVL_RST;
      rx_lvl_q  <= QSIF_LVL_RST;
      tx_lvl_q  <= QSIF_LVL_RST;
      boot_q    <= QSIF_BOOT_RST;
    end else if (wr) begin
      case (i_wb_adr)
        QSIF_ENABLE_OFS: begin
          enable_q <= (enable_q & ~lane_mask(i_wb_sel)) |
                      (i_wb_dat[11:0] & lane_mask(i_wb_sel));
        end
        QSIF_LEVEL_OFS: begin
          con_lvl_q <= i_wb_sel[0] ? i_wb_dat[QSIF_CON_LVL_POS +: QSIF_LVL_W]
                                   : con_lvl_q;
          rx_lvl_q  <= i_wb_sel[1] ? i_wb_dat[QSIF_RX_LVL_POS +: QSIF_LVL_W]
                                   : rx_lvl_q;
          tx_lvl_q  <= i_wb_sel[2] ? i_wb_dat[QSIF_TX_LVL_POS +: QSIF_LVL_W]
                                   : tx_lvl_q;
        end
        QSIF_CONTROL_OFS: begin
          if (i_wb_sel[0]) begin
            boot_q <= i_wb_dat[QSIF_BOOT_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // bus answer: registered, one cycle after the request
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wb_ack <= 1'b0;
      o_wb_err <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= acc && hit;
      o_wb_err <= acc && !hit;
      o_wb_dat <= 32'h0000_0000;
      if (acc && !i_wb_we) begin
        case (i_wb_adr)
          QSIF_STATUS_OFS:  o_wb_dat <= {20'h00000, flags_q};  // see RULE13
          QSIF_ENABLE_OFS:  o_wb_dat <= {20'h00000, enable_q};
          QSIF_LEVEL_OFS:   o_wb_dat <= {8'h00, tx_lvl_q, rx_lvl_q, con_lvl_q};
          QSIF_CONTROL_OFS: o_wb_dat <= {31'h00000000, boot_q};
          default:          o_wb_dat <= 32'h0000_0000; // clear reads zero
        endcase
      end
    end
  end

  // marks an answer in flight as a status read, for the upper-bit check
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_status_q <= 1'b0;
    end else begin
      rd_status_q <= acc && !i_wb_we && (i_wb_adr == QSIF_STATUS_OFS);
    end
  end

  // interrupt level from enabled flags
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((flags_q & ~clr_d) | set_d) & enable_q);
    end
  end

  // ==========================================================
  // checks: every hardware condition shows on the next edge
  // a dma error pulse must leave its flag behind
  property p_set_wins;
    @(posedge i_clock) disable iff (!i_nrst)
    i_dma.bus_error |=> flags_q[QSIF_DMA_ERR_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("dma flag lost"); // see RULE1

  // a finished packet must be flagged
  property p_pkt;
    @(posedge i_clock) disable iff (!i_nrst)
    i_dma.pkt_done |=> flags_q[QSIF_PKT_BIT];
  endproperty
  a_pkt: assert property (p_pkt) else $error("packet flag missed"); // see RULE2

  // finished descriptor processing must be flagged
  property p_bd;
    @(posedge i_clock) disable iff (!i_nrst)
    i_dma.bd_done |=> flags_q[QSIF_BD_BIT];
  endproperty
  a_bd: assert property (p_bd) else $error("descriptor flag missed"); // see RULE3

  // control free space above its level
  property p_con_thr;
    @(posedge i_clock) disable iff (!i_nrst)
    (i_con_buf.free_words > con_lvl_q) |=> flags_q[QSIF_CON_THR_BIT];
  endproperty
  a_con_thr: assert property (p_con_thr) else $error("con threshold missed"); // see RULE4

  // control buffer empty
  property p_con_empty;
    @(posedge i_clock) disable iff (!i_nrst)
    i_con_buf.empty |=> flags_q[QSIF_CON_EMP_BIT];
  endproperty
  a_con_empty: assert property (p_con_empty) else $error("con empty missed"); // see RULE5

  // control buffer full
  property p_con_full;
    @(posedge i_clock) disable iff (!i_nrst)
    i_con_buf.full |=> flags_q[QSIF_CON_FUL_BIT];
  endproperty
  a_con_full: assert property (p_con_full) else $error("con full missed"); // see RULE6

  // receive free space above its level
  property p_rx_thr;
    @(posedge i_clock) disable iff (!i_nrst)
    (i_rx_buf.free_words > rx_lvl_q) |=> flags_q[QSIF_RX_THR_BIT];
  endproperty
  a_rx_thr: assert property (p_rx_thr) else $error("rx threshold missed"); // see RULE7

  // receive buffer full
  property p_rx_full;
    @(posedge i_clock) disable iff (!i_nrst)
    i_rx_buf.full |=> flags_q[QSIF_RX_FUL_BIT];
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("rx full missed"); // see RULE8

  // receive buffer empty
  property p_rx_empty;
    @(posedge i_clock) disable iff (!i_nrst)
    i_rx_buf.empty |=> flags_q[QSIF_RX_EMP_BIT];
  endproperty
  a_rx_empty: assert property (p_rx_empty) else $error("rx empty missed"); // see RULE9

  // transmit free space above its level
  property p_tx_thr;
    @(posedge i_clock) disable iff (!i_nrst)
    (i_tx_buf.free_words > tx_lvl_q) |=> flags_q[QSIF_TX_THR_BIT];
  endproperty
  a_tx_thr: assert property (p_tx_thr) else $error("tx threshold missed"); // see RULE14

  // transmit buffer full
  property p_tx_full;
    @(posedge i_clock) disable iff (!i_nrst)
    i_tx_buf.full |=> flags_q[QSIF_TX_FUL_BIT];
  endproperty
  a_tx_full: assert property (p_tx_full) else $error("tx full missed"); // see RULE14

  // transmit buffer empty
  property p_tx_empty;
    @(posedge i_clock) disable iff (!i_nrst)
    i_tx_buf.empty |=> flags_q[QSIF_TX_EMP_BIT];
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty missed"); // see RULE14

  // ==========================================================
  // checks: boot hold
  // in boot mode the receive threshold flag is held until a system read
  property p_boot;
    @(posedge i_clock) disable iff (!i_nrst)
    (boot_hold_q && boot_q) |=> flags_q[QSIF_RX_THR_BIT];
  endproperty
  a_boot: assert property (p_boot) else $error("boot threshold flag low"); // see RULE10

  // the first system read ends the hold
  property p_hold_drop;
    @(posedge i_clock) disable iff (!i_nrst)
    i_sys_read_req |=> !boot_hold_q;
  endproperty
  a_hold_drop: assert property (p_hold_drop) else $error("boot hold kept"); // see RULE10

  // ==========================================================
  // checks: software side of the flags
  // a written one clears the packet flag when no new packet lands
  property p_clear;
    @(posedge i_clock) disable iff (!i_nrst)
    (wr && i_wb_adr == QSIF_STATUS_OFS && i_wb_sel[1] && i_wb_dat[QSIF_PKT_BIT] &&
     !i_dma.pkt_done) |=> !flags_q[QSIF_PKT_BIT];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared"); // see RULE11

  // a written zero leaves a set flag alone
  property p_zero_keeps;
    @(posedge i_clock) disable iff (!i_nrst)
    (wr && i_wb_adr == QSIF_STATUS_OFS && !i_wb_dat[QSIF_DMA_ERR_BIT] &&
     flags_q[QSIF_DMA_ERR_BIT]) |=> flags_q[QSIF_DMA_ERR_BIT];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost on zero"); // see RULE11

  // a set flag stays until a one is written to it
  property p_sticky;
    @(posedge i_clock) disable iff (!i_nrst)
    (flags_q[QSIF_BD_BIT] && !clr_d[QSIF_BD_BIT]) |=> flags_q[QSIF_BD_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped"); // see RULE15

  // a status read shows zeros above the flags
  property p_upper;
    @(posedge i_clock) disable iff (!i_nrst)
    (o_wb_ack && rd_status_q) |-> (o_wb_dat[31:12] == 20'h00000);
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits not zero"); // see RULE13

  // ==========================================================
  // checks: bus answer and interrupt
  // ack lasts one cycle, so no access is taken twice
  property p_ack_once;
    @(posedge i_clock) disable iff (!i_nrst)
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");

  // one answer per access, never both kinds
  property p_ack_err;
    @(posedge i_clock) disable iff (!i_nrst)
    !(o_wb_ack && o_wb_err);
  endproperty
  a_ack_err: assert property (p_ack_err) else $error("ack and err together");

  // an unmapped access leaves the interrupt enables unchanged
  property p_refused;
    @(posedge i_clock) disable iff (!i_nrst)
    (acc && !hit) |=> $stable(enable_q);
  endproperty
  a_refused: assert property (p_refused) else $error("unmapped access took effect");

  // an enabled flag left alone raises the interrupt
  property p_irq;
    @(posedge i_clock) disable iff (!i_nrst)
    ((|(flags_q & enable_q)) && !wr) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

endmodule

// ==== logic/qsif_pkg.sv ====
// Contract
// RULE1: dma bus error sets bit 11
// RULE2: packet completion sets bit 10
// RULE3: descriptor processing done sets bit 9
// RULE4: control free space above threshold sets bit 8
// RULE5: control buffer empty sets bit 7
// RULE6: control buffer full sets bit 6
// RULE7: receive free space above threshold sets bit 5
// RULE8: receive buffer full sets bit 4
// RULE9: receive buffer empty sets bit 3
// RULE10: boot mode holds bit 5 until first read
// RULE11: write one clears flag, zero keeps
// RULE12: reset value has bits 7,5,3,2,0 set
// RULE13: bits above 11 read zero, ignore writes
// RULE14: transmit conditions set bits 2,1,0
// RULE15: flags sticky; set beats clear
package qsif_pkg;
  // ==========================================================
  // register map (byte addresses, own choice)
  localparam logic [7:0]  QSIF_STATUS_OFS  = 8'h00; // status, w1c
  localparam logic [7:0]  QSIF_CLEAR_OFS   = 8'h04; // write-only clear
  localparam logic [7:0]  QSIF_ENABLE_OFS  = 8'h08; // interrupt enable
  localparam logic [7:0]  QSIF_LEVEL_OFS   = 8'h0C; // threshold settings
  localparam logic [7:0]  QSIF_CONTROL_OFS = 8'h10; // boot mode control
  // ==========================================================
  // field positions
  localparam int QSIF_FLAG_W      = 12; // implemented flag bits
  localparam int QSIF_DMA_ERR_BIT = 11;
  localparam int QSIF_PKT_BIT     = 10;
  localparam int QSIF_BD_BIT      = 9;
  localparam int QSIF_CON_THR_BIT = 8;
  localparam int QSIF_CON_EMP_BIT = 7;
  localparam int QSIF_CON_FUL_BIT = 6;
  localparam int QSIF_RX_THR_BIT  = 5;
  localparam int QSIF_RX_FUL_BIT  = 4;
  localparam int QSIF_RX_EMP_BIT  = 3;
  localparam int QSIF_TX_THR_BIT  = 2;
  localparam int QSIF_TX_FUL_BIT  = 1;
  localparam int QSIF_TX_EMP_BIT  = 0;
  localparam int QSIF_LVL_W       = 8;  // width of one threshold field
  localparam int QSIF_CON_LVL_POS = 0;  // control threshold field
  localparam int QSIF_RX_LVL_POS  = 8;  // receive threshold field
  localparam int QSIF_TX_LVL_POS  = 16; // transmit threshold field
  localparam int QSIF_BOOT_BIT    = 0;  // control: boot/xip mode
  // ==========================================================
  // reset values
  localparam logic [11:0] QSIF_FLAG_RST  = 12'h0AD; // see RULE12
  localparam logic [11:0] QSIF_EN_RST    = 12'h000;
  localparam logic [7:0]  QSIF_LVL_RST   = 8'h00;
  localparam logic        QSIF_BOOT_RST  = 1'b0;

  // buffer occupancy seen by the flag logic
  typedef struct packed {
    logic [7:0] free_words; // words of free space
    logic       empty;      // no entries
    logic       full;       // no free space
  } qsif_buf_type;

  // one-cycle dma event pulses
  typedef struct packed {
    logic bus_error;   // dma bus error
    logic pkt_done;    // descriptor packet complete
    logic bd_done;     // descriptor processing done
  } qsif_dma_type;
endpackage

// ==== dv/qsif_status_tb.sv ====
module qsif_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import qsif_pkg::*;
  // ==========================================================
  // stimulus, observation and bookkeeping
  logic         i_clock = 1'b0;  // 25 MHz
  logic         i_nrst  = 1'b0;  // async, active low
  logic         cyc     = 1'b0;  // wishbone request
  logic         stb     = 1'b0;
  logic         we      = 1'b0;
  logic [7:0]   adr     = 8'h00;
  logic [3:0]   sel     = 4'h0;
  logic [31:0]  wdat    = 32'h0;
  logic [31:0]  rdat;            // read data seen
  logic         ack;
  logic         berr;
  logic         irq;
  logic         rdreq   = 1'b0;  // system read request
  logic         got_err;         // last cycle ended in err
  qsif_dma_type dma     = '0;    // event pulses
  qsif_buf_type con     = '0;    // buffer levels, idle empty of news
  qsif_buf_type rx      = '0;
  qsif_buf_type tx      = '0;
  logic [31:0]  lv;              // threshold settings in force
  logic [31:0]  en;              // interrupt enables in force
  logic [31:0]  q;
  logic [31:0]  seed    = 32'h0000_56E8;
  int           err_total   = 0;
  int           comparisons = 0;

  always #20 i_clock = ~i_clock;

  qsif_status qsif_status_i (.i_clock(i_clock), .i_nrst(i_nrst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(berr), .i_dma(dma), .i_con_buf(con),
    .i_rx_buf(rx), .i_tx_buf(tx), .i_sys_read_req(rdreq), .o_irq(irq));

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // the one flag a single condition should leave behind
  function automatic logic [31:0] flag_of(input int b);
    return 32'h1 << b;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // classic cycle: launch after an edge, hold until ack or err is sampled
  // high at a rising edge, take the data at that edge, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= d;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (ack !== 1'b1 && berr !== 1'b1 && n < 20);
    if (ack !== 1'b1 && berr !== 1'b1) begin
      // bounded wait ran dry: slave never answered
      err_total++;
      tally_and_finish();
    end else begin
      q = rdat;
      got_err = berr;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
    end
  endtask

  // drive one hardware condition; off leaves free space at the level, not above it
  task automatic cond(input int b, input logic on);
    case (b)
      11: dma.bus_error <= on;
      10: dma.pkt_done <= on;
      9: dma.bd_done <= on;
      8: con.free_words <= lv[7:0] + {7'h0, on};
      7: con.empty <= on;
      6: con.full <= on;
      5: rx.free_words <= lv[15:8] + {7'h0, on};
      4: rx.full <= on;
      3: rx.empty <= on;
      2: tx.free_words <= lv[23:16] + {7'h0, on};
      1: tx.full <= on;
      default: tx.empty <= on;
    endcase
  endtask

  // ==========================================================
  // main sequence
  initial begin
    lv = 32'h0;
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    wb(1'b0, QSIF_STATUS_OFS, 32'h0);
    chk("status reset", {20'h0, QSIF_FLAG_RST}, q);
    chk("irq reset", 32'h0, {31'h0, irq});
    // boot mode: the receive threshold flag survives a clear until a system read
    wb(1'b1, QSIF_CONTROL_OFS, 32'h0000_0001);
    wb(1'b1, QSIF_STATUS_OFS, flag_of(QSIF_RX_THR_BIT));
    wb(1'b0, QSIF_STATUS_OFS, 32'h0);
    chk("boot hold", {20'h0, QSIF_FLAG_RST}, q);
    wb(1'b0, QSIF_CONTROL_OFS, 32'h0);
    chk("boot mode readback", 32'h0000_0001, q);
    rdreq <= 1'b1;
    @(posedge i_clock);
    rdreq <= 1'b0;
    wb(1'b1, QSIF_STATUS_OFS, 32'hFFFF_FFFF);
    wb(1'b0, QSIF_STATUS_OFS, 32'h0);
    chk("status all clear", 32'h0, q);
    wb(1'b1, 8'h20, xs());
    chk("unmapped err", 32'h1, {31'h0, got_err});
    for (int b = 0; b < QSIF_FLAG_W; b++) begin
      // free space back to zero first, so a new lower level raises nothing
      con.free_words <= 8'h00;
      rx.free_words  <= 8'h00;
      tx.free_words  <= 8'h00;
      lv = xs() & 32'h00FE_FEFE;
      en = xs() & 32'h0000_0FFF;
      rdreq <= ^xs();
      wb(1'b1, QSIF_LEVEL_OFS, lv);
      wb(1'b1, QSIF_ENABLE_OFS, en);
      wb(1'b0, QSIF_LEVEL_OFS, 32'h0);
      chk("level readback", lv, q);
      wb(1'b0, QSIF_ENABLE_OFS, 32'h0);
      chk("enable readback", en, q);
      cond(b, 1'b0);
      wb(1'b0, QSIF_STATUS_OFS, 32'h0);
      chk("status idle", 32'h0, q);
      cond(b, 1'b1);
      @(posedge i_clock);
      cond(b, 1'b0);
      wb(1'b1, QSIF_STATUS_OFS, ~flag_of(b) & 32'hFFFF_F000);
      wb(1'b0, QSIF_STATUS_OFS, 32'h0);
      chk("status flag", flag_of(b), q);
      chk("irq raised", {31'h0, en[b]}, {31'h0, irq});
      wb(1'b1, (b % 2 == 1) ? QSIF_CLEAR_OFS : QSIF_STATUS_OFS, flag_of(b));
      repeat (2) @(posedge i_clock);
      wb(1'b0, QSIF_STATUS_OFS, 32'h0);
      chk("status cleared", 32'h0, q);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    // clear while the condition persists: the set must win
    cond(3, 1'b1);
    wb(1'b1, QSIF_STATUS_OFS, flag_of(3));
    wb(1'b0, QSIF_STATUS_OFS, 32'h0);
    chk("set beats clear", flag_of(3), q);
    cond(3, 1'b0);
    wb(1'b1, QSIF_STATUS_OFS, flag_of(3));
    wb(1'b0, QSIF_CLEAR_OFS, 32'h0);
    chk("clear reg reads zero", 32'h0, q);
    wb(1'b0, QSIF_STATUS_OFS, 32'h0);
    chk("status final", 32'h0, q);
    tally_and_finish();
  end
endmodule
